// ==== design/tsac_adc_hold.sv ====
// adc setting holder: captures live settings at conversion start
// assumes conv_start comes from the converter, synchronous to pclk
`timescale 1ns/1ps
`include "tsac_regs.svh"

module tsac_adc_hold
	import tsac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic conv_start,
	input tsac_adc_cfg_type live_cfg,
	output tsac_adc_cfg_type held_cfg
);
	tsac_adc_cfg_type next_held_cfg;

	always_comb begin
		next_held_cfg = held_cfg;
		if (conv_start) begin
			next_held_cfg = live_cfg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_cfg <= '0;
			held_cfg.adc_input_or_ref_sel <= `TSAC_ADC_IN_RESET;
		end else begin
			held_cfg <= next_held_cfg;
		end
	end
endmodule

// ==== design/tsac_pkg.sv ====
// types shared by the touch-key/adc select block
// assumes nothing beyond a sv compiler
package tsac_pkg;
	typedef enum logic [1:0] {TSAC_SCAN_X1, TSAC_SCAN_X2, TSAC_SCAN_X4, TSAC_SCAN_X8} tsac_scan_mode_type;
	typedef enum logic [1:0] {TSAC_SRC_PIN, TSAC_SRC_BANDGAP, TSAC_SRC_GROUND, TSAC_SRC_QUARTER} tsac_src_kind_type;

	typedef struct packed {
		logic tk_voltage_pair_sel;
		logic tk_spread_en;
		logic tk_bundle_scan_sel;
		tsac_scan_mode_type tk_scan_repeat_mode;
		logic [3:0] scans_per_channel;
		logic [4:0] channel_limit;
		logic ref_key_present;
	} tsac_tk_cfg_type;

	typedef struct packed {
		logic [4:0] adc_input_or_ref_sel;
		tsac_src_kind_type src_kind;
		logic input_reserved;
		logic ref_is_bandgap;
		logic [1:0] bandgap_level_sel;
		logic bandgap_level_bad;
	} tsac_adc_cfg_type;
endpackage

// ==== design/tsac_regs.svh ====
// register offsets, field positions and reset values of the touch-key/adc select block
// assumes inclusion by bare name from design files
`ifndef TSAC_REGS_SVH
`define TSAC_REGS_SVH

// ==========================================================
// register indices; byte address is four times the index
`define TSAC_IDX_TOUCH_KEY 8'had
`define TSAC_IDX_ADC_SELECT 8'hae
`define TSAC_IDX_STATUS 8'hb0
`define TSAC_ADDR_W 12

// ==========================================================
// touch-key control fields
`define TSAC_TK_VPAIR_BIT 4
`define TSAC_TK_SPREAD_BIT 3
`define TSAC_TK_BUNDLE_BIT 2
`define TSAC_TK_MODE_LSB 0
`define TSAC_TK_RESET 8'h10

// ==========================================================
// scans per channel and channel limit of each scan mode
`define TSAC_SCANS_X1 4'h1
`define TSAC_SCANS_X2 4'h2
`define TSAC_SCANS_X4 4'h4
`define TSAC_SCANS_X8 4'h8
`define TSAC_LIMIT_X1 5'h17
`define TSAC_LIMIT_X2 5'h17
`define TSAC_LIMIT_X4 5'h10
`define TSAC_LIMIT_X8 5'h08

// ==========================================================
// adc select fields
`define TSAC_ADC_IN_LSB 3
`define TSAC_ADC_REF_BIT 2
`define TSAC_ADC_BG_LSB 0
`define TSAC_ADC_IN_RESET 5'h1c
`define TSAC_ADC_RESET 8'he0

// ==========================================================
// adc input codes
`define TSAC_IN_BANDGAP 5'h0c
`define TSAC_IN_GROUND 5'h0d
`define TSAC_IN_QUARTER 5'h1f

`endif

// ==== design/tsac_top.sv ====
// touch-key scanner and adc select configuration registers behind apb
// assumes apb master on pclk; converter gives conv_start pulse, scanner reads tk_cfg
`timescale 1ns/1ps
`include "tsac_regs.svh"

module tsac_top
	import tsac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`TSAC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic conv_start,
	output tsac_tk_cfg_type tk_cfg,
	output tsac_adc_cfg_type adc_cfg
);
	// ==========================================================
	// register state
	logic [7:0] touch_key_control;
	logic [7:0] adc_input_reference_select;
	logic [7:0] next_touch_key_control;
	logic [7:0] next_adc_input_reference_select;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic wr_en;
	logic rd_en;
	logic [1:0] hit;
	tsac_adc_cfg_type live_adc;
	tsac_tk_cfg_type next_tk_cfg;

	function automatic logic [1:0] tsac_decode(input logic [`TSAC_ADDR_W-1:0] a);
		logic [1:0] r;
		r = 2'h0;
		if (a == {2'h0, `TSAC_IDX_TOUCH_KEY, 2'h0}) begin
			r = 2'h1;
		end else if (a == {2'h0, `TSAC_IDX_ADC_SELECT, 2'h0}) begin
			r = 2'h2;
		end else if (a == {2'h0, `TSAC_IDX_STATUS, 2'h0}) begin
			r = 2'h3;
		end
		return r;
	endfunction

	function automatic tsac_src_kind_type tsac_src(input logic [4:0] code);
		tsac_src_kind_type k;
		k = TSAC_SRC_PIN;
		if (code == `TSAC_IN_BANDGAP) begin
			k = TSAC_SRC_BANDGAP;
		end else if (code == `TSAC_IN_GROUND) begin
			k = TSAC_SRC_GROUND;
		end else if (code == `TSAC_IN_QUARTER) begin
			k = TSAC_SRC_QUARTER;
		end
		return k;
	endfunction

	// gaps in the input code map; 1c..1e covers the reset code
	function automatic logic tsac_reserved(input logic [4:0] code);
		logic r;
		r = 1'b0;
		if (code == 5'h12) begin
			r = 1'b1;
		end else if (code == 5'h16) begin
			r = 1'b1;
		end else if (code == 5'h1a) begin
			r = 1'b1;
		end else if ((code >= 5'h1c) && (code <= 5'h1e)) begin
			r = 1'b1;
		end
		return r;
	endfunction

	// status word of the held converter settings
	function automatic logic [2:0] tsac_status(input tsac_adc_cfg_type cfg);
		return {cfg.bandgap_level_bad, cfg.input_reserved, cfg.ref_is_bandgap};
	endfunction

	// ==========================================================
	// apb access: zero wait states, read data latched in setup, write lands in access
	assign pready = 1'b1;
	assign hit = tsac_decode(paddr);
	assign wr_en = psel && penable && pwrite && pstrb[0];
	assign rd_en = psel && !penable && !pwrite;

	// ==========================================================
	// register write group
	always_comb begin
		next_touch_key_control = touch_key_control;
		next_adc_input_reference_select = adc_input_reference_select;
		if (wr_en && hit == 2'h1) begin
			next_touch_key_control = pwdata[7:0];
		end else if (wr_en && hit == 2'h2) begin
			next_adc_input_reference_select = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			touch_key_control <= `TSAC_TK_RESET;
			adc_input_reference_select <= `TSAC_ADC_RESET;
		end else begin
			touch_key_control <= next_touch_key_control;
			adc_input_reference_select <= next_adc_input_reference_select;
		end
	end

	// ==========================================================
	// bus response group: error flag decided in setup, held over access
	always_comb begin
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (rd_en) begin
			if (hit == 2'h1) begin
				next_prdata = {24'h0, touch_key_control};
			end else if (hit == 2'h2) begin
				next_prdata = {24'h0, adc_input_reference_select};
			end else if (hit == 2'h3) begin
				next_prdata = {29'h0, tsac_status(adc_cfg)};
			end else begin
				next_prdata = 32'h0;
			end
		end
		if (psel && !penable && hit == 2'h0) begin
			next_pslverr = 1'b1;
		end else if (psel && penable) begin
			next_pslverr = pslverr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ==========================================================
	// touch-key decode from the next register value, so flops change with the write
	always_comb begin
		next_tk_cfg.tk_voltage_pair_sel = next_touch_key_control[`TSAC_TK_VPAIR_BIT];
		next_tk_cfg.tk_spread_en = next_touch_key_control[`TSAC_TK_SPREAD_BIT];
		next_tk_cfg.tk_bundle_scan_sel = next_touch_key_control[`TSAC_TK_BUNDLE_BIT];
		next_tk_cfg.tk_scan_repeat_mode = tsac_scan_mode_type'(next_touch_key_control[`TSAC_TK_MODE_LSB +: 2]);
		case (next_tk_cfg.tk_scan_repeat_mode)
			TSAC_SCAN_X1: begin
				next_tk_cfg.scans_per_channel = `TSAC_SCANS_X1;
				next_tk_cfg.channel_limit = `TSAC_LIMIT_X1;
				next_tk_cfg.ref_key_present = 1'b1;
			end
			TSAC_SCAN_X2: begin
				next_tk_cfg.scans_per_channel = `TSAC_SCANS_X2;
				next_tk_cfg.channel_limit = `TSAC_LIMIT_X2;
				next_tk_cfg.ref_key_present = 1'b1;
			end
			TSAC_SCAN_X4: begin
				next_tk_cfg.scans_per_channel = `TSAC_SCANS_X4;
				next_tk_cfg.channel_limit = `TSAC_LIMIT_X4;
				next_tk_cfg.ref_key_present = 1'b0;
			end
			default: begin
				next_tk_cfg.scans_per_channel = `TSAC_SCANS_X8;
				next_tk_cfg.channel_limit = `TSAC_LIMIT_X8;
				next_tk_cfg.ref_key_present = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// decode of the touch-key reset value 10h
			tk_cfg.tk_voltage_pair_sel <= 1'b1;
			tk_cfg.tk_spread_en <= 1'b0;
			tk_cfg.tk_bundle_scan_sel <= 1'b0;
			tk_cfg.tk_scan_repeat_mode <= TSAC_SCAN_X1;
			tk_cfg.scans_per_channel <= `TSAC_SCANS_X1;
			tk_cfg.channel_limit <= `TSAC_LIMIT_X1;
			tk_cfg.ref_key_present <= 1'b1;
		end else begin
			tk_cfg <= next_tk_cfg;
		end
	end

	// ==========================================================
	// adc decode, latched per conversion
	always_comb begin
		live_adc.adc_input_or_ref_sel = adc_input_reference_select[`TSAC_ADC_IN_LSB +: 5];
		live_adc.src_kind = tsac_src(live_adc.adc_input_or_ref_sel);
		live_adc.input_reserved = tsac_reserved(live_adc.adc_input_or_ref_sel);
		live_adc.ref_is_bandgap = adc_input_reference_select[`TSAC_ADC_REF_BIT];
		live_adc.bandgap_level_sel = adc_input_reference_select[`TSAC_ADC_BG_LSB +: 2];
		live_adc.bandgap_level_bad = live_adc.ref_is_bandgap &&
			(live_adc.bandgap_level_sel != 2'h1);
	end

	// ==========================================================
	// per-conversion holder of the converter settings
	tsac_adc_hold i_tsac_adc_hold (
		.pclk(pclk),
		.presetn(presetn),
		.conv_start(conv_start),
		.live_cfg(live_adc),
		.held_cfg(adc_cfg)
	);
endmodule

// ==== test/tb_touch_scan_adc_select_cfg.sv ====
// bench: apb register access, touch-key decode, held adc settings
// assumes tsac_pkg and checker compiled first
`timescale 1ns/1ps
module tb_touch_scan_adc_select_cfg
	import tsac_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_start = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, d;
	logic [3:0] pstrb = 0;
	logic pready, pslverr, er;
	logic [15:0] lf = 16'd38462;
	logic [7:0] tkm, hm = 8'he0;
	logic [4:0] cs [6] = '{5'h0c, 5'h0d, 5'h1f, 5'h03, 5'h1b, 5'h1d};
	logic [1:0] ks [6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
	logic rs [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	// byte addresses: register index times four
	localparam logic [11:0] A_TK = 12'h2b4;
	localparam logic [11:0] A_ADC = 12'h2b8;
	localparam logic [11:0] A_ST = 12'h2c0;
	int n_fail = 0, num_checks = 0;
	tsac_tk_cfg_type tk_cfg;
	tsac_adc_cfg_type adc_cfg;
	wire [7:0] held = {adc_cfg.adc_input_or_ref_sel, adc_cfg.ref_is_bandgap, adc_cfg.bandgap_level_sel};
	always #12.5 pclk = ~pclk;
	tsac_top i_tsac_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .conv_start, .tk_cfg, .adc_cfg);
	always @(posedge pclk) if (psel && penable && pready) begin
		rd <= prdata;
		er <= pslverr;
	end
	// ==========
	// helpers
	function logic [15:0] lfsr();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction
	task finish_test();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, v, s};
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			finish_test();
		end
		{psel, penable} <= 2'b00;
		#1;
	endtask
	// ==========
	// sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		apb(0, A_TK, 0, 0);
		chk("tk rst", 5'h10, rd[4:0]);
		chk("vpair rst", 1, tk_cfg.tk_voltage_pair_sel);
		apb(0, A_ADC, 0, 0);
		chk("adc rst", 8'he0, rd[7:0]);
		chk("err", 0, er);
		apb(0, 12'h0a4, 0, 0);
		chk("unmap rd", 0, rd);
		chk("unmap err", 1, er);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			d = {lfsr(), lfsr()};
			d[1:0] = i[1:0];
			tkm = d[7:0];
			apb(1, A_TK, d, 4'h1);
			chk("vpair", tkm[4], tk_cfg.tk_voltage_pair_sel);
			chk("spread", tkm[3], tk_cfg.tk_spread_en);
			chk("bundle", tkm[2], tk_cfg.tk_bundle_scan_sel);
			chk("scans", 1 << tkm[1:0], tk_cfg.scans_per_channel);
			chk("limit", tkm[1] ? (tkm[0] ? 8 : 16) : 23, tk_cfg.channel_limit);
		end
		apb(1, A_TK, ~d, 4'he);
		apb(0, A_TK, 0, 0);
		chk("tk rd", tkm[4:0], rd[4:0]);
		$display("test touch done");
		for (int i = 0; i < 6; i++) begin
			d = lfsr();
			d[7:3] = cs[i];
			if (d[2] && d[1:0] == 2'h0) d[1:0] = 2'h1;
			apb(1, A_ADC, d, 4'h1);
			chk("held", hm, held);
			@(posedge pclk) conv_start <= 1;
			@(posedge pclk) conv_start <= 0;
			#1;
			hm = d[7:0];
			chk("input", hm[7:3], adc_cfg.adc_input_or_ref_sel);
			chk("kind", ks[i], adc_cfg.src_kind);
			chk("rsv", rs[i], adc_cfg.input_reserved);
			chk("ref", hm[2], adc_cfg.ref_is_bandgap);
			chk("level", hm[1:0], adc_cfg.bandgap_level_sel);
			chk("bad", hm[2] && hm[1:0] != 2'h1, adc_cfg.bandgap_level_bad);
			apb(0, A_ADC, 0, 0);
			chk("adc rd", hm, rd[7:0]);
			apb(0, A_ST, 0, 0);
			chk("status", {hm[2] && hm[1:0] != 2'h1, rs[i], hm[2]}, rd[2:0]);
			chk("st err", 0, er);
		end
		$display("test adc done");
		@(posedge pclk) presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		hm = 8'he0;
		apb(0, A_TK, 0, 0);
		chk("tk rerst", 5'h10, rd[4:0]);
		chk("vpair rerst", 1, tk_cfg.tk_voltage_pair_sel);
		apb(0, A_ADC, 0, 0);
		chk("adc rerst", hm, rd[7:0]);
		chk("held rerst", hm, held);
		$display("test mid reset done");
		finish_test();
	end
endmodule

// ==== test/tsac_checker.sv ====
// checker: tsac_top field decode, write effect, held adc settings
// assumes bind onto tsac_top ports
`timescale 1ns/1ps
module tsac_checker
	import tsac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic conv_start,
	input tsac_tk_cfg_type tk_cfg,
	input tsac_adc_cfg_type adc_cfg
);
	// ==========
	// properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire w = psel && penable && pwrite && pstrb[0] && paddr == 12'h2b4;
	wire [1:0] m = tk_cfg.tk_scan_repeat_mode;
	wire [4:0] c = adc_cfg.adc_input_or_ref_sel;
	property p_vp; w |=> tk_cfg.tk_voltage_pair_sel == $past(pwdata[4]); endproperty
	a_vp: assert property (p_vp) else $error("vpair");
	property p_sp; w |=> tk_cfg.tk_spread_en == $past(pwdata[3]); endproperty
	a_sp: assert property (p_sp) else $error("spread");
	property p_bu; w |=> tk_cfg.tk_bundle_scan_sel == $past(pwdata[2]); endproperty
	a_bu: assert property (p_bu) else $error("bundle");
	property p_md; w |=> m == $past(pwdata[1:0]); endproperty
	a_md: assert property (p_md) else $error("mode");
	property p_dec; tk_cfg.scans_per_channel == 4'h1 << m && !tk_cfg.ref_key_present == m[1]
		&& tk_cfg.channel_limit == (m[1] ? (m[0] ? 5'h08 : 5'h10) : 5'h17); endproperty
	a_dec: assert property (p_dec) else $error("scan decode");
	property p_src; adc_cfg.src_kind == (c == 5'h0c ? 2'h1 : c == 5'h0d ? 2'h2 : c == 5'h1f ? 2'h3 : 2'h0); endproperty
	a_src: assert property (p_src) else $error("source kind");
	property p_bad; adc_cfg.bandgap_level_bad == (adc_cfg.ref_is_bandgap && adc_cfg.bandgap_level_sel != 2'h1); endproperty
	a_bad: assert property (p_bad) else $error("low level flag");
	property p_hold; !conv_start |=> $stable(adc_cfg); endproperty
	a_hold: assert property (p_hold) else $error("held changed");
endmodule

bind tsac_top tsac_checker i_tsac_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.conv_start, .tk_cfg, .adc_cfg);
